// ---- bulk_data_defines.svh ----
/*
  Register map, field codes, file size and file names of the bulk data file control block.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef BULK_DATA_DEFINES_SVH
`define BULK_DATA_DEFINES_SVH

// Byte addresses on the 8-bit APB address
`define SET_SEL_BIT       6
`define MISC_BIT          7
`define REG_STATUS        6'h00
`define REG_CONTROL       6'h04
`define REG_INFO          6'h08
`define REG_NAME_FIRST    6'h0C
`define REG_NAME_LAST     6'h1C
`define REG_SIZE          6'h20
`define REG_SHD_ENABLE    8'h80
`define REG_ACTIVE        8'h84
`define REG_WORK_CFG      8'h88
`define REG_WORK_SHD      8'h8C

// Control function codes
`define FN_ENUMERATE      8'h00
`define FN_NEXT           8'h01
`define FN_ERASE          8'h04
`define FN_ACTIVATE       8'h05
`define FN_COPY           8'h06

// Info and status codes
`define INFO_MORE         8'h00
`define INFO_LAST         8'h01
`define INFO_ERROR        8'h02
`define INFO_ACTIVE       8'h04
`define STATUS_OK         8'h01
`define FILE_BYTES        32'h0000_0004

// File identifiers and names (ASCII, first character leftmost)
`define NAME_CHARS        20
`define FID_FACTORY       3'h0
`define FID_USER_FIRST    3'h1
`define FID_CFG_LAST      3'h4
`define FID_NONE          3'h7
`define NAME_USER_PREFIX  64'h5573657253657430
`define CHAR_ZERO         8'h30
`define NAME_FACTORY_CFG  80'h466163746F7279536574
`define NAME_USER_SHD     88'h5573657253686164696E67
`define NAME_FACTORY_SHD  112'h466163746F727953686164696E67

`endif

// ---- bulk_data_pkg.sv ----
/*
  Types and name helpers of the bulk data file control block.
  Assumes bulk_data_defines.svh is on the include path.
*/
package bulk_data_pkg;
`include "bulk_data_defines.svh"

    typedef logic [159:0] name_t;
    typedef logic [2:0]   fid_t;

    typedef enum logic [1:0] {ST_RELOAD = 2'b01, ST_IDLE = 2'b10} ctl_state_t;

    typedef struct packed {
        logic [4:0][31:0] cfg;
        logic [4:0]       cfg_saved;
        fid_t             cfg_active;
        logic [31:0]      shd_user;
        logic             shd_user_saved;
        fid_t             shd_active;
    } nv_regs_t;

    typedef struct packed {
        ctl_state_t       state;
        logic [1:0][7:0]  ctrl;
        logic [1:0][7:0]  info;
        logic [1:0][159:0] name;
        logic [1:0][2:0]  scan;
        logic             shd_enable;
        logic [31:0]      work_cfg;
        logic [31:0]      work_shd;
        logic [31:0]      shd_out;
        logic [31:0]      rdata;
        logic             ready;
        logic             err;
    } ctl_regs_t;

    // Reverses character order: register layout <-> first-character-leftmost
    function automatic name_t swap_chars(input name_t n);
        name_t o;
        o = '0;
        for (int k = 0; k < `NAME_CHARS; k++)
        begin
            o[8*k +: 8] = n[8*(`NAME_CHARS-1-k) +: 8];
        end
        return o;
    endfunction

    function automatic name_t name_of(input logic shd, input fid_t fid);
        name_t be;
        be = '0;
        if (shd)
        begin
            if (fid == `FID_FACTORY)
                be = {`NAME_FACTORY_SHD, 48'h0};
            else
                be = {`NAME_USER_SHD, 72'h0};
        end
        else if (fid == `FID_FACTORY)
            be = {`NAME_FACTORY_CFG, 80'h0};
        else
            be = {`NAME_USER_PREFIX, `CHAR_ZERO + {5'h0, fid}, 88'h0};
        return swap_chars(be);
    endfunction

    function automatic fid_t file_of(input logic shd, input name_t n);
        fid_t f;
        f = `FID_NONE;
        for (int i = 0; i < 5; i++)
        begin
            if ((!shd || i < 2) && n == name_of(shd, fid_t'(i)))
                f = fid_t'(i);
        end
        return f;
    endfunction

endpackage

// ---- nv_file_store.sv ----
/*
  Non-volatile file store: five configuration files, the user shading file and
  the activation links. Only the power-on reset clears it; the block reset leaves it.
  Assumes the controller issues at most one operation per cycle.
*/
`timescale 1ns/1ps
`include "bulk_data_defines.svh"
module nv_file_store
    import bulk_data_pkg::*;
#(
    parameter logic [31:0] FACTORY_CFG_VALUE = 32'h0000_0000,
    parameter logic [31:0] FACTORY_SHD_VALUE = 32'h0000_0000
)(
    // Clock and power-on reset
    input  wire logic         pclk,
    input  wire logic         por_n,
    // Operations
    input  wire logic         cfg_wr,
    input  wire logic         cfg_erase,
    input  wire logic         cfg_act,
    input  wire logic         shd_copy,
    input  wire logic         shd_act,
    input  wire fid_t         op_idx,
    input  wire logic [31:0]  cfg_wr_data,
    // Contents
    output logic [159:0]      cfg_files,
    output logic [4:0]        cfg_saved,
    output fid_t              cfg_active,
    output logic [63:0]       shd_files,
    output logic [1:0]        shd_saved,
    output fid_t              shd_active
);

    localparam nv_regs_t NV_RESET = '{
        cfg:            {128'h0, FACTORY_CFG_VALUE},
        cfg_saved:      5'h01,
        cfg_active:     `FID_FACTORY,
        shd_user:       32'h0000_0000,
        shd_user_saved: 1'b0,
        shd_active:     `FID_FACTORY
    };

    nv_regs_t q;
    nv_regs_t d;

    always_comb
    begin
        d = q;
        if (cfg_wr)
        begin
            d.cfg[op_idx]       = cfg_wr_data;
            d.cfg_saved[op_idx] = 1'b1;
        end
        if (cfg_erase)
            d.cfg_saved[op_idx] = 1'b0;
        if (cfg_act)
            d.cfg_active = op_idx;
        if (shd_copy)
        begin
            d.shd_user       = FACTORY_SHD_VALUE;
            d.shd_user_saved = 1'b1;
        end
        if (shd_act)
            d.shd_active = op_idx;
    end

    always_ff @(posedge pclk or negedge por_n)
    begin
        if (!por_n)
            q <= NV_RESET;
        else
            q <= d;
    end

    assign cfg_files  = q.cfg;
    assign cfg_saved  = q.cfg_saved;
    assign cfg_active = q.cfg_active;
    assign shd_files  = {q.shd_user, FACTORY_SHD_VALUE};
    assign shd_saved  = {q.shd_user_saved, 1'b1};
    assign shd_active = q.shd_active;

endmodule

// ---- bulk_data_file_control.sv ----
/*
  Bulk data file control: two file control registers (configuration sets and
  shading values) on APB, enumeration, activation, copy and reload after reset.
  Assumes the camera parameter logic reports working-set changes on cfg_set_*.
*/
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "bulk_data_defines.svh"
module bulk_data_file_control
    import bulk_data_pkg::*;
#(
    parameter logic [31:0] FACTORY_CFG_VALUE = 32'h0000_0000,
    parameter logic [31:0] FACTORY_SHD_VALUE = 32'h0000_0000
)(
    // Clock and resets
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         por_n,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Working configuration from the camera parameter logic
    input  wire logic         cfg_set_valid,
    input  wire logic [31:0]  cfg_set_data,
    // Working sets
    output logic [31:0]       work_cfg,
    output logic [31:0]       shading_values,
    output logic              shading_enabled
);

    // Controller state and its next value
    ctl_regs_t    q;
    ctl_regs_t    d;

    // File store contents
    logic [159:0] cfg_files;
    logic [4:0]   cfg_saved;
    fid_t         cfg_active;
    logic [63:0]  shd_files;
    logic [1:0]   shd_saved;
    fid_t         shd_active;

    // File store operations
    logic         cfg_wr;
    logic         cfg_erase;
    logic         cfg_act;
    logic         shd_copy;
    logic         shd_act;
    fid_t         op_idx;

    // Decode and scan
    logic         wr_take;
    logic         rd_take;
    logic         t;
    logic [5:0]   loc;
    logic [2:0]   word;
    fid_t         fid;
    fid_t         start;
    fid_t         hit;
    logic         found;
    logic [4:0]   saved;
    fid_t         active;
    logic         known;
    logic [31:0]  rd_val;
    logic         rd_hit;

    // Only por_n clears the files
    nv_file_store #(
        .FACTORY_CFG_VALUE (FACTORY_CFG_VALUE),
        .FACTORY_SHD_VALUE (FACTORY_SHD_VALUE)
    ) u_store (
        .pclk        (pclk),
        .por_n       (por_n),
        .cfg_wr      (cfg_wr),
        .cfg_erase   (cfg_erase),
        .cfg_act     (cfg_act),
        .shd_copy    (shd_copy),
        .shd_act     (shd_act),
        .op_idx      (op_idx),
        .cfg_wr_data (q.work_cfg),
        .cfg_files   (cfg_files),
        .cfg_saved   (cfg_saved),
        .cfg_active  (cfg_active),
        .shd_files   (shd_files),
        .shd_saved   (shd_saved),
        .shd_active  (shd_active)
    );

    // Combinational answer, registered data
    assign pready  = penable & q.ready;
    assign pslverr = pready & q.err;
    assign prdata  = q.rdata;

    // Working sets seen by the camera
    assign work_cfg        = q.work_cfg;
    assign shading_values  = q.shd_out;
    assign shading_enabled = q.shd_enable;

    // Register decode shared by reads and writes
    always_comb
    begin
        t      = paddr[`SET_SEL_BIT];
        loc    = paddr[5:0];
        word   = 3'((loc - `REG_NAME_FIRST) >> 2);
        saved  = t ? {3'h0, shd_saved} : cfg_saved;
        active = t ? shd_active : cfg_active;

        // Only the fixed file names map to a file
        fid    = file_of(t, q.name[t]);
        known  = (fid != `FID_NONE) && saved[fid];
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;

        if (paddr[`MISC_BIT])
        begin
            if (paddr == `REG_SHD_ENABLE)
                rd_val = {31'h0, q.shd_enable};
            else if (paddr == `REG_ACTIVE)
                rd_val = {25'h0, shd_active, 1'b0, cfg_active};
            else if (paddr == `REG_WORK_CFG)
                rd_val = q.work_cfg;
            else if (paddr == `REG_WORK_SHD)
                rd_val = q.work_shd;
            else
                rd_hit = 1'b0;
        end
        // Both sets share this layout; bit 6 picks one
        else if (loc == `REG_STATUS)
            rd_val = {24'h0, `STATUS_OK};
        else if (loc == `REG_CONTROL)
            rd_val = {24'h0, q.ctrl[t]};
        else if (loc == `REG_INFO)
            rd_val = {24'h0, q.info[t]};
        else if (loc >= `REG_NAME_FIRST && loc <= `REG_NAME_LAST && loc[1:0] == 2'b00)
            rd_val = q.name[t][32*word +: 32];
        else if (loc == `REG_SIZE)
            rd_val = known ? `FILE_BYTES : 32'h0000_0000;
        else
            rd_hit = 1'b0;
    end

    // Enumeration scan: first saved file at or after the start point
    always_comb
    begin
        // A finished list stays finished until the next enumerate
        if (pwdata[7:0] != `FN_NEXT)
            start = `FID_FACTORY;
        else if (q.scan[t] == `FID_NONE)
            start = `FID_NONE;
        else
            start = q.scan[t] + 3'h1;
        hit   = `FID_NONE;
        found = 1'b0;

        // Descending loop: the lowest saved index wins
        for (int i = 4; i >= 0; i--)
        begin
            if (saved[i] && i >= int'(start) && !(start == `FID_NONE))
            begin
                hit   = fid_t'(i);
                found = 1'b1;
            end
        end
    end

    always_comb
    begin
        d         = q;

        cfg_wr    = 1'b0;
        cfg_erase = 1'b0;
        cfg_act   = 1'b0;
        shd_copy  = 1'b0;
        shd_act   = 1'b0;
        op_idx    = fid;

        wr_take   = psel & penable & pready & pwrite;
        rd_take   = psel & penable & pready;

        case (q.state)
            ST_RELOAD:
            begin
                // Fetch the linked files once after reset
                d.work_cfg = cfg_files[32*cfg_active +: 32];
                d.work_shd = shd_files[32*shd_active[0] +: 32];
                d.state    = ST_IDLE;
            end

            ST_IDLE:
            begin
                // Camera edits of the working set; an activate overrides them
                if (cfg_set_valid)
                    d.work_cfg = cfg_set_data;

                if (wr_take && paddr == `REG_SHD_ENABLE)
                    d.shd_enable = pwdata[0];
                else if (wr_take && !paddr[`MISC_BIT])
                begin
                    // Name words are stored as written
                    if (loc >= `REG_NAME_FIRST && loc <= `REG_NAME_LAST && loc[1:0] == 2'b00)
                        d.name[t][32*word +: 32] = pwdata;
                    else if (loc == `REG_CONTROL)
                    begin
                        d.ctrl[t] = pwdata[7:0];
                        d.info[t] = `INFO_MORE;
                        case (pwdata[7:0])
                            `FN_ENUMERATE, `FN_NEXT:
                            begin
                                if (found)
                                begin
                                    d.name[t] = name_of(t, hit);
                                    d.scan[t] = hit;
                                    if (hit == active)
                                        d.info[t] = `INFO_ACTIVE;
                                    else
                                        d.info[t] = `INFO_MORE;
                                end
                                else
                                begin
                                    d.scan[t] = `FID_NONE;
                                    d.info[t] = `INFO_LAST;
                                end
                            end

                            `FN_ACTIVATE:
                            begin
                                if (!known)
                                    d.info[t] = `INFO_ERROR;
                                else if (t)
                                begin
                                    shd_act    = 1'b1;
                                    d.work_shd = shd_files[32*fid[0] +: 32];
                                end
                                else
                                begin
                                    cfg_act    = 1'b1;
                                    d.work_cfg = cfg_files[32*fid +: 32];
                                end
                            end

                            // Configuration copy saves the working set from before this edge; shading copy stores FACTORY_SHD_VALUE
                            `FN_COPY:
                            begin
                                if (fid == `FID_NONE || fid == `FID_FACTORY)
                                    d.info[t] = `INFO_ERROR;
                                else if (t)
                                    shd_copy = 1'b1;
                                else
                                    cfg_wr = 1'b1;
                            end

                            // Erase keeps the link; reload then uses old content
                            `FN_ERASE:
                            begin
                                if (!known || fid == `FID_FACTORY || t)
                                    d.info[t] = `INFO_ERROR;
                                else
                                    cfg_erase = 1'b1;
                            end

                            default:
                                d.info[t] = `INFO_ERROR;
                        endcase
                    end
                end
            end

            default:
                d.state = ST_RELOAD;
        endcase

        // Correction output follows the enable at the same edge
        d.shd_out = d.shd_enable ? d.work_shd : 32'h0000_0000;

        // Zero wait states after reload, one while reloading
        if (psel && !rd_take)
        begin
            d.ready = (q.state == ST_IDLE);
            d.err   = !rd_hit;
            d.rdata = rd_val;
        end
        else
        begin
            d.ready = 1'b0;
            d.err   = 1'b0;
        end
    end

    // Block reset keeps the file store and its links
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q.state      <= ST_RELOAD;
            q.ctrl       <= '0;
            q.info       <= '0;
            q.name       <= '0;
            // A next before any enumerate reports the end
            q.scan       <= {2{`FID_NONE}};
            q.shd_enable <= 1'b0;
            q.work_cfg   <= 32'h0000_0000;
            q.work_shd   <= 32'h0000_0000;
            q.shd_out    <= 32'h0000_0000;
            q.rdata      <= 32'h0000_0000;
            q.ready      <= 1'b0;
            q.err        <= 1'b0;
        end
        else
            q <= d;
    end

endmodule

// ---- bulk_data_file_control_chk.sv ----
/*
  Port checker of the bulk data file control block.
  Assumes it is bound to the block's top module, with pclk and presetn as its domain.
*/
`timescale 1ns/1ps
module bulk_data_file_control_chk (
    // Clock and resets
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        por_n,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Working sets
    input wire logic        cfg_set_valid,
    input wire logic [31:0] cfg_set_data,
    input wire logic [31:0] work_cfg,
    input wire logic [31:0] shading_values,
    input wire logic        shading_enabled
);
    logic settled_q;
    logic fin;
    logic mapped;
    logic act_cfg;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Masks the reload edge right after reset
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            settled_q <= 1'b0;
        else
            settled_q <= 1'b1;

    assign fin     = psel & penable & pready;
    assign mapped  = paddr[1:0] == 2'b00
                     && (paddr[7] ? paddr[6:4] == 3'h0 : paddr[5:0] <= 6'h20);
    assign act_cfg = fin && pwrite && paddr == 8'h04 && pwdata[7:0] == 8'h05;

    property p_ready_access;
        pready |-> psel && penable;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("pready outside access");
    property p_one_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not answered");
    property p_err_map;
        fin |-> pslverr == !mapped;
    endproperty
    a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
    property p_err_data;
        fin && pslverr |-> prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("data on refused access");
    property p_status;
        fin && !pwrite && !paddr[7] && paddr[5:0] == 6'h00 |-> prdata == 32'h1;
    endproperty
    a_status: assert property (p_status) else $error("status word wrong");
    property p_shd_gate;
        !shading_enabled |-> shading_values == 32'h0;
    endproperty
    a_shd_gate: assert property (p_shd_gate) else $error("shading applied while off");
    property p_shd_enable;
        fin && pwrite && paddr == 8'h80 |=> shading_enabled == $past(pwdata[0]);
    endproperty
    a_shd_enable: assert property (p_shd_enable) else $error("enable not written");
    property p_cfg_track;
        cfg_set_valid && !act_cfg |=> work_cfg == $past(cfg_set_data);
    endproperty
    a_cfg_track: assert property (p_cfg_track) else $error("working set not taken");
    property p_cfg_hold;
        settled_q && !cfg_set_valid && !(fin && pwrite && paddr == 8'h04) |=> $stable(work_cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("working set changed");
endmodule

bind bulk_data_file_control bulk_data_file_control_chk chk (
    .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cfg_set_valid, .cfg_set_data, .work_cfg, .shading_values, .shading_enabled
);

// ---- host_apb_model.sv ----
/*
  Host model: issues register commands over APB, one transfer at a time.
  Assumes a free-running pclk and tasks called right after a rising edge.
*/
`timescale 1ns/1ps
module host_apb_model (
    // Clock
    input  wire logic        pclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Set when a slave never answered
    output logic             stuck
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        stuck   = 1'b0;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        stuck = stuck | (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released write data carries no stale value
        pwdata  <= ~d;
        @(posedge pclk);
    endtask

    // Name words first, then the function, on the same register set
    task automatic command(input logic [7:0] base, input logic [127:0] nm,
                           input logic named, input logic [7:0] fn);
        logic [31:0] q;
        logic        e;
        if (named)
        begin
            for (int k = 0; k < 4; k++)
            begin
                xfer(1'b1, base + 8'h0C + 8'(4 * k), nm[32*k +: 32], q, e);
            end
            xfer(1'b1, base + 8'h1C, 32'h0, q, e);
        end
        xfer(1'b1, base + 8'h04, {24'h0, fn}, q, e);
    endtask
endmodule

// ---- bulk_data_file_control_bench.sv ----
/*
  Self-checking bench of the bulk data file control block.
  Assumes the checker is bound to the block and the host model drives APB.
*/
`timescale 1ns/1ps
module bulk_data_file_control_bench;
    localparam logic [31:0] FCFG = 32'h0000_C0DE;
    localparam logic [31:0] FSHD = 32'h5A5A_0F0F;
    localparam logic [7:0]  C    = 8'h00;
    localparam logic [7:0]  S    = 8'h40;
    localparam logic [2:0]  N    = 3'h7;

    typedef struct packed {
        logic [7:0] base;
        logic [2:0] nm;
        logic [7:0] fn;
        logic [7:0] info;
        logic [2:0] show;
    } row_t;

    // File names as register words, first character in the low byte
    logic [127:0] names [7] = '{
        {32'h0, 32'h0000_7465, 32'h5379_726F, 32'h7463_6146},
        {32'h0, 32'h0000_0031, 32'h3074_6553, 32'h7265_7355},
        {32'h0, 32'h0000_0032, 32'h3074_6553, 32'h7265_7355},
        {32'h0, 32'h0000_0033, 32'h3074_6553, 32'h7265_7355},
        {32'h0, 32'h0000_0034, 32'h3074_6553, 32'h7265_7355},
        {32'h0000_676E, 32'h6964_6168, 32'h5379_726F, 32'h7463_6146},
        {32'h0, 32'h0067_6E69, 32'h6461_6853, 32'h7265_7355}
    };
    // Register set, name, function, info, name shown afterwards
    row_t rows [24] = '{
        '{C,N,8'h00,8'h04,3'h0}, '{C,N,8'h01,8'h01,3'h0}, '{C,3'h2,8'h06,8'h00,N},
        '{C,3'h0,8'h06,8'h02,N}, '{C,3'h4,8'h06,8'h00,N}, '{C,N,8'h00,8'h04,3'h0},
        '{C,N,8'h01,8'h00,3'h2}, '{C,N,8'h01,8'h00,3'h4}, '{C,N,8'h01,8'h01,3'h4},
        '{C,N,8'h01,8'h01,3'h4},
        '{C,3'h3,8'h05,8'h02,N}, '{C,N,8'h02,8'h02,N}, '{C,N,8'h03,8'h02,N},
        '{C,N,8'h07,8'h02,N}, '{C,3'h4,8'h05,8'h00,N}, '{C,3'h2,8'h04,8'h00,N},
        '{C,N,8'h00,8'h00,3'h0}, '{C,N,8'h01,8'h04,3'h4}, '{S,N,8'h00,8'h04,3'h5},
        '{S,3'h6,8'h05,8'h02,N}, '{S,3'h6,8'h06,8'h00,N}, '{S,3'h6,8'h05,8'h00,N},
        '{S,N,8'h00,8'h00,3'h5}, '{S,N,8'h01,8'h04,3'h6}
    };

    logic        pclk;
    logic        presetn       = 1'b0;
    logic        por_n         = 1'b0;
    logic        cfg_set_valid = 1'b0;
    logic [31:0] cfg_set_data  = 32'h0;
    logic        psel, penable, pwrite, pready, pslverr, stuck, shading_enabled;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, work_cfg, shading_values, q;
    logic        e;
    int          error_cnt     = 0;
    int          tests_run     = 0;

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    host_apb_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                         .pready, .pslverr, .stuck);
    bulk_data_file_control #(.FACTORY_CFG_VALUE(FCFG), .FACTORY_SHD_VALUE(FSHD)) dut (
        .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cfg_set_valid, .cfg_set_data, .work_cfg, .shading_values,
        .shading_enabled);

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang_check();
        if (stuck)
        begin
            error_cnt++;
            conclude();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        host.xfer(w, a, d, q, e);
        hang_check();
    endtask

    task automatic cmd(input logic [7:0] base, input logic [2:0] nm, input logic [7:0] fn);
        host.command(base, names[nm == N ? 3'h0 : nm], nm != N, fn);
        hang_check();
    endtask

    task automatic set_work(input logic [31:0] v);
        cfg_set_valid <= 1'b1;
        cfg_set_data  <= v;
        @(posedge pclk);
        cfg_set_valid <= 1'b0;
        cfg_set_data  <= ~v;
    endtask

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        @(posedge pclk);
        set_work(32'h0000_00A1);
        foreach (rows[i])
        begin
            cmd(rows[i].base, rows[i].nm, rows[i].fn);
            bus(1'b0, rows[i].base + 8'h08, 32'h0);
            chk("info", {24'h0, rows[i].info}, {24'h0, q[7:0]});
            if (rows[i].show != N)
            begin
                bus(1'b0, rows[i].base + 8'h14, 32'h0);
                chk("name word", names[rows[i].show][95:64], q);
                bus(1'b0, rows[i].base + 8'h18, 32'h0);
                chk("name tail", names[rows[i].show][127:96], q);
            end
        end
        $display("table done");
        set_work(32'h1111_0001);
        cmd(C, 3'h1, 8'h06);
        set_work(32'h2222_0002);
        cmd(C, 3'h1, 8'h06);
        set_work(32'h3333_0003);
        cmd(C, 3'h1, 8'h05);
        chk("work_cfg", 32'h2222_0002, work_cfg);
        bus(1'b0, 8'h88, 32'h0);
        chk("work reg", 32'h2222_0002, q);
        $display("overwrite done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("reload", 32'h2222_0002, work_cfg);
        chk("gated", 32'h0, shading_values);
        bus(1'b1, 8'h80, 32'h1);
        @(posedge pclk);
        chk("shading", FSHD, shading_values);
        $display("reload done");
        cmd(C, 3'h0, 8'h05);
        chk("factory", FCFG, work_cfg);
        cmd(S, 3'h5, 8'h05);
        bus(1'b0, 8'h84, 32'h0);
        chk("links", 32'h0, q);
        bus(1'b0, 8'hF0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        bus(1'b1, 8'h00, 32'hFF);
        bus(1'b0, 8'h00, 32'h0);
        chk("status", 32'h1, q);
        bus(1'b0, 8'h40, 32'h0);
        chk("shd status", 32'h1, q);
        $display("refusal done");
        conclude();
    end
endmodule
